/* File: hw/ssf_status_flags.sv */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - status loads 0x84 at reset, standby or module stop.
// - writing 1 to clearable flags does nothing; 0 clears only after reading 1.
// - transmit-end and received multiprocessor bit ignore writes.
// - transmit-empty set while transmit disabled or buffer moves to shifter.
// - transmit-empty clears by armed 0 write or controller buffer write.
// - receive-full sets when an error-free character reaches receive buffer.
// - receive-full clears by armed 0 write or controller buffer read.
// - receive buffer and receive-full hold on error or receive disabled.
// - overrun sets when a character completes while receive-full is set.
// - any error flag stalls reception, and transmission in synchronous mode.
// - disabling reception leaves overrun, framing and parity flags alone.
// - framing error when first stop bit is 0 in asynchronous mode.
// - framing error still stores character but not receive-full.
// - parity mismatch sets parity error in asynchronous mode; character stored, no receive-full.
// - transmit-end shows transmission ended with empty transmit buffer.
// - transmit-end set when disabled or empty at last bit; clears with empty.
// - received multiprocessor bit captures each accepted character's bit in asynchronous multiprocessor mode.
// - transmit multiprocessor bit is read/write and appended on transmit.
`include "ssf_consts.svh"
module ssf_status_flags (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic standby,
    input wire logic moduleStop,
    input wire ssf_pkg::ssf_addr_t regAddr,
    input wire ssf_pkg::ssf_byte_t regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output ssf_pkg::ssf_byte_t regRdData,
    input wire logic transmitEnable,
    input wire logic receiveEnable,
    input wire logic syncMode,
    input wire logic parityEnable,
    input wire logic parityOdd,
    input wire logic multiprocMode,
    input wire logic txLoad,
    input wire logic txLastBit,
    input wire logic rxDone,
    input wire ssf_pkg::ssf_byte_t rxData,
    input wire logic rxParityBit,
    input wire logic rxStopBit,
    input wire logic rxMpBit,
    input wire logic dtcTxWrite,
    input wire ssf_pkg::ssf_byte_t dtcTxData,
    input wire logic dtcRxRead,
    output ssf_pkg::ssf_byte_t transmitBuffer,
    output ssf_pkg::ssf_byte_t receiveBuffer,
    output logic transmitMultiprocBit,
    output logic transmitEmptyFlag,
    output logic receiveFullFlag,
    output logic transmitEndFlag,
    output logic rxStall,
    output logic txStall,
    output logic irq
);

    function automatic logic hit(input ssf_pkg::ssf_addr_t a,
                                 input ssf_pkg::ssf_addr_t off);
        hit = (a == off);
    endfunction

    // five clear-after-read flags, index 4..0 = status bits 7..3
    ssf_pkg::ssf_flags_t flags;
    ssf_pkg::ssf_flags_t armed;
    ssf_pkg::ssf_flags_t next_flags;
    ssf_pkg::ssf_flags_t next_armed;
    ssf_pkg::ssf_flags_t flagSet;
    ssf_pkg::ssf_flags_t hwClr;
    ssf_pkg::ssf_flags_t swClr;
    logic receivedMpb;
    ssf_pkg::ssf_irq_t irqStat;
    ssf_pkg::ssf_irq_t irqMask;
    ssf_pkg::ssf_irq_t irqEvent;
    ssf_pkg::ssf_byte_t statusValue;
    ssf_pkg::ssf_byte_t rdMux;

    wire initState = !rst_b || standby || moduleStop;

    wire wrStatus = regWrStrobe && hit(regAddr, `SSF_OFF_STATUS);
    wire rdStatus = regRdStrobe && hit(regAddr, `SSF_OFF_STATUS);
    wire wrTxBuf = regWrStrobe && hit(regAddr, `SSF_OFF_TXBUF);
    wire wrIrqStat = regWrStrobe && hit(regAddr, `SSF_OFF_IRQ_STAT);
    wire wrIrqMask = regWrStrobe && hit(regAddr, `SSF_OFF_IRQ_MASK);

    wire txEmpty = flags[`SSF_BIT_TX_EMPTY - `SSF_FLAG_LSB];
    wire rxFull = flags[`SSF_BIT_RX_FULL - `SSF_FLAG_LSB];
    wire overrun = flags[`SSF_BIT_OVERRUN - `SSF_FLAG_LSB];
    wire framing = flags[`SSF_BIT_FRAMING - `SSF_FLAG_LSB];
    wire parityErr = flags[`SSF_BIT_PARITY - `SSF_FLAG_LSB];

    // any error freezes the receiver; synchronous mode also freezes tx
    assign rxStall = overrun || framing || parityErr;
    assign txStall = syncMode && rxStall;

    // a completed character counts only while enabled and not stalled
    wire rxAccept = rxDone && receiveEnable && !rxStall;
    wire asyncAccept = rxAccept && !syncMode;
    wire stopBad = asyncAccept && !rxStopBit;
    wire parityBad = asyncAccept && parityEnable
                     && ((^{rxData, rxParityBit}) != parityOdd);
    wire overrunEv = rxAccept && rxFull;
    // framing or parity errored characters still land in the buffer, good ones raise full
    wire rxStore = rxAccept && !rxFull;
    wire rxGood = rxStore && !stopBad && !parityBad;

    wire txEmptySet = !transmitEnable || txLoad;
    wire txEndSet = !transmitEnable
                    || (txLastBit && txEmpty);

    assign flagSet[`SSF_BIT_TX_EMPTY - `SSF_FLAG_LSB] = txEmptySet;
    assign flagSet[`SSF_BIT_RX_FULL - `SSF_FLAG_LSB] = rxGood;
    assign flagSet[`SSF_BIT_OVERRUN - `SSF_FLAG_LSB] = overrunEv;
    assign flagSet[`SSF_BIT_FRAMING - `SSF_FLAG_LSB] = stopBad;
    assign flagSet[`SSF_BIT_PARITY - `SSF_FLAG_LSB] = parityBad;

    // transfer-controller side clears
    assign hwClr[`SSF_BIT_TX_EMPTY - `SSF_FLAG_LSB] = dtcTxWrite;
    assign hwClr[`SSF_BIT_RX_FULL - `SSF_FLAG_LSB] = dtcRxRead;
    assign hwClr[`SSF_BIT_OVERRUN - `SSF_FLAG_LSB] = 1'b0;
    assign hwClr[`SSF_BIT_FRAMING - `SSF_FLAG_LSB] = 1'b0;
    assign hwClr[`SSF_BIT_PARITY - `SSF_FLAG_LSB] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < `SSF_NFLAGS; i = i + 1)
        begin : g_flag
            // zero write clears only an armed flag; one write is ignored
            assign swClr[i] = wrStatus && armed[i]
                              && !regWrData[i + `SSF_FLAG_LSB];
            // set beats any clear in the same cycle
            assign next_flags[i] = flagSet[i]
                || (flags[i] && !swClr[i] && !hwClr[i]);
            // read of one arms; any status write or flag drop disarms
            assign next_armed[i] = (rdStatus && flags[i])
                || (armed[i] && !wrStatus && flags[i]);
        end
    endgenerate

    wire txEmptyClr = swClr[`SSF_BIT_TX_EMPTY - `SSF_FLAG_LSB]
                      || dtcTxWrite;
    wire next_txEnd = txEndSet
                      || (transmitEndFlag && !txEmptyClr);

    assign irqEvent[`SSF_IRQ_TX_EMPTY] = txEmptySet && !txEmpty;
    assign irqEvent[`SSF_IRQ_RX_FULL] = rxGood;
    assign irqEvent[`SSF_IRQ_ERROR] = overrunEv || stopBad || parityBad;
    assign irqEvent[`SSF_IRQ_TX_END] = txEndSet && !transmitEndFlag;

    assign statusValue = {flags, transmitEndFlag, receivedMpb,
                          transmitMultiprocBit};

    assign rdMux = hit(regAddr, `SSF_OFF_STATUS) ? statusValue
        : hit(regAddr, `SSF_OFF_RXBUF) ? receiveBuffer
        : hit(regAddr, `SSF_OFF_TXBUF) ? transmitBuffer
        : hit(regAddr, `SSF_OFF_IRQ_STAT) ? {4'h0, irqStat}
        : hit(regAddr, `SSF_OFF_IRQ_MASK) ? {4'h0, irqMask}
        : 8'h00;

    assign transmitEmptyFlag = txEmpty;
    assign receiveFullFlag = rxFull;
    assign irq = |(irqStat & irqMask);

    // status register, loaded with 0x84 also by standby and module stop
    always_ff @(posedge clk)
    begin
        if (initState)
        begin
            flags <= ssf_pkg::ssf_flags_t'(`SSF_STATUS_RESET
                >> `SSF_FLAG_LSB);
            armed <= 5'h00;
            transmitEndFlag <= 1'b1;
            receivedMpb <= 1'b0;
            transmitMultiprocBit <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            armed <= next_armed;
            transmitEndFlag <= next_txEnd;
            if (rxAccept && multiprocMode && !syncMode)
            begin
                receivedMpb <= rxMpBit;
            end
            if (wrStatus)
            begin
                transmitMultiprocBit <=
                    regWrData[`SSF_BIT_TX_MPB];
            end
        end
    end

    // data buffers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            receiveBuffer <= 8'h00;
            transmitBuffer <= 8'h00;
        end
        else
        begin
            if (rxStore)
            begin
                receiveBuffer <= rxData;
            end
            if (dtcTxWrite)
            begin
                transmitBuffer <= dtcTxData;
            end
            else if (wrTxBuf)
            begin
                transmitBuffer <= regWrData;
            end
        end
    end

    // interrupt status (write one to clear, set wins) and mask
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            irqStat <= `SSF_IRQ_RESET;
            irqMask <= `SSF_IRQ_RESET;
        end
        else
        begin
            irqStat <= irqEvent | (irqStat
                & ~(wrIrqStat ? regWrData[3:0] : 4'h0));
            if (wrIrqMask)
            begin
                irqMask <= regWrData[3:0];
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            regRdData <= regRdStrobe ? rdMux : 8'h00;
        end
    end

endmodule

/* File: include/ssf_consts.svh */
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

// register map (byte index on the plain register port)
`define SSF_ADDR_W 3
`define SSF_OFF_STATUS 3'h0
`define SSF_OFF_RXBUF 3'h1
`define SSF_OFF_TXBUF 3'h2
`define SSF_OFF_IRQ_STAT 3'h3
`define SSF_OFF_IRQ_MASK 3'h4

// status register layout
`define SSF_STATUS_RESET 8'h84
`define SSF_BIT_TX_EMPTY 7
`define SSF_BIT_RX_FULL 6
`define SSF_BIT_OVERRUN 5
`define SSF_BIT_FRAMING 4
`define SSF_BIT_PARITY 3
`define SSF_BIT_TX_END 2
`define SSF_BIT_RX_MPB 1
`define SSF_BIT_TX_MPB 0
// the five clear-after-read flags sit in bits 7..3
`define SSF_NFLAGS 5
`define SSF_FLAG_LSB 3

// interrupt status / mask layout
`define SSF_IRQ_W 4
`define SSF_IRQ_TX_EMPTY 0
`define SSF_IRQ_RX_FULL 1
`define SSF_IRQ_ERROR 2
`define SSF_IRQ_TX_END 3
`define SSF_IRQ_RESET 4'h0

`endif

/* File: include/ssf_pkg.sv */
package ssf_pkg;
    typedef logic [7:0] ssf_byte_t;
    typedef logic [2:0] ssf_addr_t;
    typedef logic [3:0] ssf_irq_t;
    typedef logic [4:0] ssf_flags_t;
endpackage

/* File: verif/ssf_status_flags_chk.sv */
`timescale 1ns/10ps
module ssf_status_flags_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic standby,
    input wire logic moduleStop,
    input wire logic receiveEnable,
    input wire logic syncMode,
    input wire logic parityEnable,
    input wire logic rxDone,
    input wire ssf_pkg::ssf_byte_t rxData,
    input wire logic rxStopBit,
    input wire logic txLoad,
    input wire logic txLastBit,
    input wire ssf_pkg::ssf_byte_t receiveBuffer,
    input wire logic transmitEmptyFlag,
    input wire logic receiveFullFlag,
    input wire logic transmitEndFlag,
    input wire logic rxStall,
    input wire logic txStall
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic take = rxDone && receiveEnable && !rxStall && !standby
        && !moduleStop;
    property p_reset;
        disable iff (1'b0) !rst_b |=> transmitEmptyFlag && transmitEndFlag
            && !receiveFullFlag && !rxStall;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset");
    property p_load; txLoad |=> transmitEmptyFlag; endproperty
    a_load: assert property (p_load) else $error("no empty");
    property p_last; txLastBit && transmitEmptyFlag |=> transmitEndFlag;
    endproperty
    a_last: assert property (p_last) else $error("no end");
    property p_hold;
        rxDone && (!receiveEnable || rxStall) |=> $stable(receiveBuffer);
    endproperty
    a_hold: assert property (p_hold) else $error("buffer moved");
    property p_good;
        take && !receiveFullFlag && (syncMode || rxStopBit && !parityEnable)
            |=> receiveFullFlag && receiveBuffer == $past(rxData);
    endproperty
    a_good: assert property (p_good) else $error("no store");
    property p_over;
        take && receiveFullFlag |=> rxStall && $stable(receiveBuffer);
    endproperty
    a_over: assert property (p_over) else $error("no overrun");
    property p_frame;
        take && !syncMode && !rxStopBit && !receiveFullFlag |=> rxStall
            && !receiveFullFlag && receiveBuffer == $past(rxData);
    endproperty
    a_frame: assert property (p_frame) else $error("bad framing");
    property p_stall; txStall == (syncMode && rxStall); endproperty
    a_stall: assert property (p_stall) else $error("bad stall");
endmodule
bind ssf_status_flags ssf_status_flags_chk u_ssf_status_flags_chk (.*);

/* File: verif/ssf_peer.sv */
`timescale 1ns/10ps
module ssf_peer (
    input wire logic clk,
    output logic rxDone,
    output ssf_pkg::ssf_byte_t rxData,
    output logic rxParityBit,
    output logic rxStopBit,
    output logic rxMpBit,
    output logic txLoad,
    output logic txLastBit
);
    initial
    begin
        {rxDone, txLoad, txLastBit} = 3'h0;
        {rxData, rxParityBit, rxStopBit, rxMpBit} = 11'h5a5;
    end
    // lines turn to junk once the character strobe drops
    task automatic recv(input ssf_pkg::ssf_byte_t d, input logic s,
        input logic p);
        @(posedge clk);
        rxDone <= 1'b1;
        {rxData, rxParityBit, rxStopBit, rxMpBit} <= {d, p, s, d[0]};
        @(posedge clk);
        rxDone <= 1'b0;
        {rxData, rxParityBit, rxStopBit, rxMpBit} <= ~{d, p, s, d[0]};
        #1;
    endtask
    task automatic txPulse(input logic last);
        @(posedge clk);
        {txLoad, txLastBit} <= {!last, last};
        @(posedge clk);
        {txLoad, txLastBit} <= 2'h0;
        #1;
    endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [5:0] mode = 6'h01;
    ssf_pkg::ssf_addr_t regAddr = 3'h0;
    ssf_pkg::ssf_byte_t regWrData = 8'h00;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    ssf_pkg::ssf_byte_t regRdData, rxData, transmitBuffer, receiveBuffer;
    logic transmitEnable, receiveEnable, syncMode, parityEnable, parityOdd;
    logic multiprocMode, txLoad, txLastBit, rxDone, rxParityBit, rxStopBit;
    logic rxMpBit, transmitMultiprocBit, transmitEmptyFlag, receiveFullFlag;
    logic transmitEndFlag, rxStall, txStall, irq;
    int miscompares = 0;
    int comparisons = 0;
    assign {multiprocMode, parityOdd, parityEnable, syncMode, receiveEnable,
        transmitEnable} = mode;
    always #12.5 clk = ~clk;
    ssf_status_flags u_ssf_status_flags (.*, .dtcTxWrite(ev[0]),
        .dtcRxRead(ev[1]), .standby(ev[2]), .moduleStop(ev[3]),
        .dtcTxData(8'h3c));
    ssf_peer u_ssf_peer (.*);
    task automatic chk(input string n, input ssf_pkg::ssf_byte_t e,
        input ssf_pkg::ssf_byte_t g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input ssf_pkg::ssf_addr_t a, input ssf_pkg::ssf_byte_t d);
        @(posedge clk);
        {regWrStrobe, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge clk);
        regWrStrobe <= 1'b0;
        #1;
    endtask
    task automatic rd(input ssf_pkg::ssf_addr_t a, input ssf_pkg::ssf_byte_t e);
        @(posedge clk);
        {regRdStrobe, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1 chk("regRdData", e, regRdData);
    endtask
    task automatic evt(input logic [3:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 4'h0;
        #1;
    endtask
    task automatic setMode(input logic [5:0] m);
        @(posedge clk) mode <= m;
    endtask
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(3'h0, 8'h84);
        wr(3'h0, 8'hff);
        chk("transmit_multiproc_bit", 8'h01, {7'h0, transmitMultiprocBit});
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h84);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h00);
        u_ssf_peer.txPulse(1'b0);
        rd(3'h0, 8'h80);
        u_ssf_peer.txPulse(1'b1);
        rd(3'h0, 8'h84);
        evt(4'h1);
        rd(3'h0, 8'h00);
        chk("txbuf", 8'h3c, transmitBuffer);
        wr(3'h2, 8'h5e);
        rd(3'h2, 8'h5e);
        chk("txbuf", 8'h5e, transmitBuffer);
        setMode(6'h07);
        u_ssf_peer.recv(8'ha5, 1'b0, 1'b0);
        rd(3'h1, 8'ha5);
        u_ssf_peer.recv(8'h11, 1'b1, 1'b0);
        chk("txStall", 8'h01, {7'h0, txStall});
        setMode(6'h01);
        u_ssf_peer.recv(8'hee, 1'b1, 1'b0);
        rd(3'h0, 8'h60);
        chk("rxbuf", 8'ha5, receiveBuffer);
        wr(3'h0, 8'h00);
        setMode(6'h03);
        u_ssf_peer.recv(8'h77, 1'b0, 1'b0);
        rd(3'h0, 8'h10);
        chk("rxbuf", 8'h77, receiveBuffer);
        wr(3'h0, 8'h00);
        setMode(6'h0b);
        u_ssf_peer.recv(8'h01, 1'b1, 1'b0);
        rd(3'h0, 8'h08);
        wr(3'h0, 8'h00);
        setMode(6'h3b);
        u_ssf_peer.recv(8'h03, 1'b1, 1'b1);
        rd(3'h0, 8'h42);
        evt(4'h2);
        rd(3'h0, 8'h02);
        wr(3'h4, 8'h02);
        chk("irq", 8'h01, {7'h0, irq});
        wr(3'h3, 8'h0f);
        chk("irq", 8'h00, {7'h0, irq});
        rd(3'h7, 8'h00);
        evt(4'h4);
        rd(3'h0, 8'h84);
        wr(3'h0, 8'h00);
        evt(4'h8);
        rd(3'h0, 8'h84);
        conclude();
    end
endmodule
